// ### ref_lock_chk.sv
// assertion checker on the ports of the reference lock controller
`timescale 1ns/1ps
module ref_lock_chk #(
  parameter logic [31:0] QUALIFY_CYCLES = 32'h0000_0014,
  parameter logic [31:0] GENLOCK_CYCLES = 32'h0000_00C8
) (
  input wire logic                clk_sys,
  input wire logic                rst,
  input wire logic [7:0]          addr,
  input wire logic [31:0]         wdata,
  input wire logic                wr,
  input wire logic                rd,
  input wire logic [31:0]         rdata,
  input wire refsel_pkg::ref_in_s ref_in,
  input wire refsel_pkg::steer_s  steer,
  input wire logic                lost_event
);
  import refsel_pkg::*;
  // ****************
  // port properties
  // ****************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_reset_quiet: assert property ($fell(rst) |-> steer == '0 && !lost_event)
    else $error("outputs not quiet after reset");
  a_rdata_idle: assert property (!rd |=> rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  a_lost_sticky: assert property (lost_event && !(wr && addr == 8'h0C && wdata[0])
    |=> lost_event)
    else $error("lost flag dropped without a clear");
  a_lost_on_drop: assert property ($fell(ref_in.video_present)
    && steer.active_src == SRC_GENLOCK |-> ##[1:3] lost_event)
    else $error("reference loss gave no lost flag");
  a_src_legal: assert property (steer.active_src <= SRC_SAT_FREQ_ONLY)
    else $error("active source outside the six settings");
  a_freq_only: assert property (steer.active_src == SRC_FREQ_REF |-> !steer.lock_phase)
    else $error("frequency reference steering phase");
  a_slew_order: assert property (!(steer.coarse_slew && steer.fine_slew))
    else $error("coarse and fine slew together");
  a_discipline_sat: assert property (steer.discipline
    |-> steer.active_src inside {SRC_SAT_FREQ_PH, SRC_SAT_FREQ_ONLY})
    else $error("oscillator disciplined outside satellite lock");
endmodule : ref_lock_chk

// ### ref_source.sv
// far-side model: video, frequency and satellite reference front ends
`timescale 1ns/1ps
module ref_source (
  input  wire logic                clk_sys,
  input  wire logic                video_on,
  input  wire refsel_pkg::ref_fmt_e fmt,
  input  wire logic                freq_on,
  input  wire logic                sat_on,
  input  wire logic                tc_on,
  input  wire logic [3:0]          ntp_cfg,
  input  wire refsel_pkg::steer_s  steer,
  output refsel_pkg::ref_in_s      ref_in
);
  import refsel_pkg::*;
  logic [7:0] vcnt_q;
  logic [7:0] scnt_q;
  logic       flock_q;
  // ****************
  // reference timing
  // ****************
  // alignment appears some time after the reference is applied, never at once
  always_ff @(posedge clk_sys)
  begin
    if (!video_on)
      vcnt_q <= 8'h00;
    else if (vcnt_q != 8'hFF)
      vcnt_q <= vcnt_q + 8'h01;
  end
  always_ff @(posedge clk_sys)
  begin
    if (!(sat_on && steer.discipline))
      scnt_q <= 8'h00;
    else if (scnt_q != 8'hFF)
      scnt_q <= scnt_q + 8'h01;
  end
  always_ff @(posedge clk_sys)
  begin
    flock_q <= freq_on && steer.lock_freq;
  end
  always_comb
  begin
    ref_in                = '0;
    ref_in.video_present  = video_on;
    ref_in.video_fmt      = video_on ? fmt : FMT_NONE;
    ref_in.coarse_aligned = vcnt_q >= 8'h1E;
    ref_in.sc_aligned     = vcnt_q >= 8'h28;
    ref_in.sch_aligned    = vcnt_q >= 8'h32;
    ref_in.tc_valid       = video_on && tc_on;
    ref_in.tc_aligned     = video_on && tc_on && vcnt_q >= 8'h32;
    ref_in.freq_present   = freq_on;
    ref_in.freq_locked    = flock_q;
    ref_in.sat_enabled    = sat_on;
    ref_in.sat_fix        = sat_on;
    ref_in.sat_time_ok    = scnt_q >= 8'h04;
    ref_in.sat_basic_ok   = scnt_q >= 8'h08;
    ref_in.sat_better_ok  = scnt_q >= 8'h0C;
    ref_in.sat_phase_ok   = scnt_q >= 8'h10;
    // ntp_cfg: enabled, client, server, synced
    ref_in.ntp_enabled    = ntp_cfg[3];
    ref_in.ntp_client     = ntp_cfg[2];
    ref_in.ntp_server     = ntp_cfg[1];
    ref_in.ntp_synced     = ntp_cfg[0];
  end
endmodule : ref_source

// ### reference_lock_controller.sv
// reference selection and lock sequencing for the video timing generator
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "refsel_defs.svh"

module reference_lock_controller #(
  parameter logic [31:0] QUALIFY_CYCLES = `QUALIFY_CYC,
  parameter logic [31:0] GENLOCK_CYCLES = `GENLOCK_CYC
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [7:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [31:0]            rdata,
  input  wire refsel_pkg::ref_in_s ref_in,
  output refsel_pkg::steer_s     steer,
  output logic                   lost_event
);
  import refsel_pkg::*;

  // ************************************************************
  // operator settings
  // ************************************************************
  lock_src_e  mode_q;
  logic       relock_q;
  sat_depth_e depth_q;
  logic       lost_flag_q;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mode_q   <= lock_src_e'(`RST_LOCK_MODE);
      relock_q <= `RST_UNLOCK_MODE;
      depth_q  <= sat_depth_e'(`RST_SAT_DEPTH);
    end
    else if (wr)
    begin
      if (addr == `OFS_LOCK_MODE && wdata[2:0] <= 3'h5)
      begin
        // satellite settings only accepted while that option is present
        if (!(wdata[2:0] >= 3'h4 && !ref_in.sat_enabled))
          mode_q <= lock_src_e'(wdata[2:0]);
      end
      if (addr == `OFS_UNLOCK_MODE)
        relock_q <= wdata[0];
      if (addr == `OFS_SAT_DEPTH && wdata[1:0] <= 2'h2)
        depth_q <= sat_depth_e'(wdata[1:0]);
    end
  end

  // ************************************************************
  // reference format and change detection
  // ************************************************************
  ref_fmt_e fmt_q;
  ref_fmt_e fmt_d;
  logic     fmt_bad;

  always_comb
  begin
    fmt_d   = ref_in.video_present ? ref_in.video_fmt : FMT_NONE;
    fmt_bad = ref_in.video_present && (ref_in.video_fmt == FMT_NONE
              || ref_in.video_fmt == ref_fmt_e'(2'h3));
    if (fmt_bad)
      fmt_d = FMT_NONE;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      fmt_q <= FMT_NONE;
    else
      fmt_q <= fmt_d;
  end

  // ************************************************************
  // genlock sequencer
  // ************************************************************
  gen_state_e gs_q;
  logic [31:0] tmr_q;
  logic        held_internal_q;
  logic        gen_mode;
  logic        ref_good;
  logic        ref_change;

  assign gen_mode   = (mode_q == SRC_GENLOCK) || (mode_q == SRC_GENLOCK_TC);
  assign ref_good   = ref_in.video_present && !fmt_bad;
  assign ref_change = ref_good && fmt_q != FMT_NONE && fmt_d != fmt_q;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      gs_q            <= GS_IDLE;
      tmr_q           <= 32'h0000_0000;
      held_internal_q <= 1'b0;
    end
    else if (!gen_mode)
    begin
      gs_q            <= GS_IDLE;
      tmr_q           <= 32'h0000_0000;
      held_internal_q <= 1'b0;
    end
    else
    begin
      tmr_q <= tmr_q + 32'h0000_0001;
      case (gs_q)
        GS_IDLE:
        begin
          tmr_q <= 32'h0000_0000;
          if (ref_good && !held_internal_q)
            gs_q <= GS_QUALIFY;
        end
        GS_QUALIFY:
        begin
          if (!ref_good || ref_change)
            gs_q <= GS_LOST;
          else if (tmr_q >= QUALIFY_CYCLES - 32'h0000_0001)
          begin
            gs_q  <= GS_COARSE;
            tmr_q <= 32'h0000_0000;
          end
        end
        GS_COARSE, GS_FINE_SC, GS_FINE_SCH:
        begin
          if (!ref_good || ref_change)
            gs_q <= GS_LOST;
          else if (tmr_q >= GENLOCK_CYCLES)
            gs_q <= GS_LOST;
          else if (gs_q == GS_COARSE && ref_in.coarse_aligned)
            gs_q <= GS_FINE_SC;
          else if (gs_q == GS_FINE_SC && ref_in.sc_aligned)
            gs_q <= GS_FINE_SCH;
          else if (gs_q == GS_FINE_SCH && ref_in.sch_aligned)
            gs_q <= GS_LOCKED;
        end
        GS_LOCKED:
        begin
          if (!ref_good || ref_change)
            gs_q <= GS_LOST;
        end
        GS_LOST:
        begin
          tmr_q <= 32'h0000_0000;
          if (!ref_in.video_present)
          begin
            gs_q            <= GS_IDLE;
            held_internal_q <= !relock_q;
          end
          else if (ref_good && relock_q && !ref_change)
            gs_q <= GS_QUALIFY;
        end
        default:
          gs_q <= GS_IDLE;
      endcase
    end
  end

  // ************************************************************
  // timecode loop
  // ************************************************************
  tc_stat_e tc_q;
  logic [31:0] tc_tmr_q;

  always_ff @(posedge clk_sys)
  begin
    if (rst || mode_q != SRC_GENLOCK_TC)
    begin
      tc_q     <= TC_IGNORING;
      tc_tmr_q <= 32'h0000_0000;
    end
    else
    begin
      tc_tmr_q <= tc_tmr_q + 32'h0000_0001;
      case (tc_q)
        TC_IGNORING:
        begin
          tc_q     <= TC_START;
          tc_tmr_q <= 32'h0000_0000;
        end
        TC_START:
          if (tc_tmr_q >= `BRIEF_CYC)
            tc_q <= TC_SEARCH;
        TC_SEARCH:
          if (ref_in.tc_valid)
          begin
            tc_q     <= TC_FOUND;
            tc_tmr_q <= 32'h0000_0000;
          end
        TC_FOUND:
          if (tc_tmr_q >= `BRIEF_CYC)
            tc_q <= TC_LOCKING;
        TC_LOCKING:
          if (!ref_in.tc_valid)
            tc_q <= TC_SEARCH;
          else if (ref_in.tc_aligned && gs_q == GS_LOCKED)
            tc_q <= TC_LOCKED;
        TC_LOCKED:
          if (!ref_in.tc_valid)
            tc_q <= TC_SEARCH;
        default:
          tc_q <= TC_IGNORING;
      endcase
    end
  end

  // ************************************************************
  // satellite and network time status
  // ************************************************************
  sat_stat_e sat_q;
  sat_stat_e sat_d;
  ntp_stat_e ntp_q;
  ntp_stat_e ntp_d;
  logic      sat_mode;

  assign sat_mode = (mode_q == SRC_SAT_FREQ_PH) || (mode_q == SRC_SAT_FREQ_ONLY);

  always_comb
  begin
    sat_d = SAT_IDLE;
    if (!ref_in.sat_enabled)
      sat_d = SAT_OFF;
    else if (sat_mode)
    begin
      // climb one step at a time, never past the selected depth
      sat_d = SAT_ACQUIRING;
      if (ref_in.sat_fix && ref_in.sat_time_ok)
      begin
        sat_d = SAT_TIME;
        if (depth_q != DEPTH_TIME && ref_in.sat_basic_ok)
        begin
          sat_d = SAT_BASIC;
          if (ref_in.sat_better_ok)
          begin
            sat_d = SAT_BETTER;
            if (depth_q == DEPTH_PHASE && mode_q == SRC_SAT_FREQ_PH
                && ref_in.sat_phase_ok)
              sat_d = SAT_PHASE;
          end
        end
      end
    end
    if (!ref_in.ntp_enabled)
      ntp_d = NTP_OPT_OFF;
    else if (ref_in.ntp_server)
      ntp_d = NTP_SERVER;
    else if (!ref_in.ntp_client)
      ntp_d = NTP_DISABLED;
    else if (ref_in.ntp_synced)
      ntp_d = NTP_LOCKED;
    else
      ntp_d = NTP_ACQUIRING;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sat_q <= SAT_IDLE;
      ntp_q <= NTP_OPT_OFF;
    end
    else
    begin
      sat_q <= sat_d;
      ntp_q <= ntp_d;
    end
  end

  // ************************************************************
  // source choice, lock status and steering
  // ************************************************************
  lock_stat_e lk_q;
  lock_stat_e lk_d;
  steer_s     steer_d;

  always_comb
  begin
    steer_d = '0;
    steer_d.active_src = SRC_INTERNAL;
    lk_d = LK_INTERNAL;
    if (gen_mode && gs_q != GS_IDLE)
    begin
      steer_d.active_src = mode_q;
      steer_d.lock_freq  = 1'b1;
      steer_d.lock_phase = 1'b1;
      steer_d.coarse_slew = (gs_q == GS_COARSE) || (gs_q == GS_QUALIFY);
      steer_d.fine_slew  = (gs_q == GS_FINE_SC) || (gs_q == GS_FINE_SCH)
                           || (gs_q == GS_LOCKED);
      if (gs_q == GS_LOST)
      begin
        lk_d = LK_LOST;
        steer_d.active_src = SRC_INTERNAL;
        steer_d.lock_freq  = 1'b0;
        steer_d.lock_phase = 1'b0;
        steer_d.coarse_slew = 1'b0;
        steer_d.fine_slew  = 1'b0;
      end
      else if (gs_q == GS_LOCKED)
        lk_d = LK_LOCKED;
      else
        lk_d = LK_LOCKING;
    end
    else if (mode_q == SRC_FREQ_REF && ref_in.freq_present)
    begin
      steer_d.active_src = SRC_FREQ_REF;
      steer_d.lock_freq  = 1'b1;
      if (ref_in.freq_locked)
        lk_d = LK_FREQ_REF;
      else
        lk_d = LK_LOCKING;
    end
    else if (sat_mode && ref_in.sat_enabled && ref_in.sat_fix)
    begin
      steer_d.active_src = mode_q;
      steer_d.discipline = 1'b1;
      steer_d.lock_freq  = depth_q != DEPTH_TIME;
      steer_d.lock_phase = depth_q == DEPTH_PHASE && mode_q == SRC_SAT_FREQ_PH;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      lk_q        <= LK_INTERNAL;
      steer       <= '0;
      lost_flag_q <= 1'b0;
    end
    else
    begin
      lk_q  <= lk_d;
      steer <= steer_d;
      // a new loss wins over a clear in the same cycle
      if (lk_d == LK_LOST && lk_q != LK_LOST)
        lost_flag_q <= 1'b1;
      else if (wr && addr == `OFS_EVENT && wdata[0])
        lost_flag_q <= 1'b0;
    end
  end

  assign lost_event = lost_flag_q;

  // ************************************************************
  // register read port
  // ************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rdata <= 32'h0000_0000;
    else if (rd)
    begin
      case (addr)
        `OFS_LOCK_MODE:   rdata <= {29'h0, mode_q};
        `OFS_UNLOCK_MODE: rdata <= {31'h0, relock_q};
        `OFS_SAT_DEPTH:   rdata <= {30'h0, depth_q};
        `OFS_EVENT:       rdata <= {31'h0, lost_flag_q};
        `OFS_STATUS:      rdata <= {9'h0, steer.active_src, 1'b0, tc_q, 1'b0, ntp_q,
                                    1'b0, sat_q, 2'h0, fmt_q, 1'b0, lk_q};
        default:          rdata <= 32'h0000_0000;
      endcase
    end
    else
      rdata <= 32'h0000_0000;
  end

endmodule : reference_lock_controller

// ### refsel_defs.svh
// constants and rule summary for the reference lock controller
//
// Contract
// - no reference selected: free-run internal oscillator
// - lock source selector offers six settings
// - video locks frequency and phase; oscillator frequency
// - satellite disciplines oscillator; depth time/freq/phase selectable
// - qualify video within 2s, then coarse lock
// - fine lock to subcarrier then SC-H phase
// - both lock phases glide timing, no jumps
// - genlock may take 15s; timeouts allow
// - relock policy: stay internal or relock
// - internal-lock status when internal or reference absent
// - lost-lock on reference change, loss, unknown format
// - locking during acquisition, locked when done; the code reports internal lock throughout the satellite modes
// - distinct locked-to-frequency-reference status
// - format: none, 525 59.94i, 625 50i
// - satellite option off reports option-off
// - satellite status steps up to selected depth
// - network time status five enumerated values
// - timecode status ignoring or start-search-found-locking-locked
// - several valid references: fixed priority selection; the code uses only the source set by the lock mode register
`ifndef REFSEL_DEFS_SVH
`define REFSEL_DEFS_SVH

// register offsets
`define OFS_LOCK_MODE    8'h00
`define OFS_UNLOCK_MODE  8'h04
`define OFS_STATUS       8'h08
`define OFS_EVENT        8'h0C
`define OFS_SAT_DEPTH    8'h10

// status register field positions
`define FLD_LOCK_LSB     0
`define FLD_FMT_LSB      4
`define FLD_SAT_LSB      8
`define FLD_NTP_LSB      12
`define FLD_TC_LSB       16
`define FLD_SRC_LSB      20

// reset values
`define RST_LOCK_MODE    3'h0
`define RST_UNLOCK_MODE  1'h1
`define RST_SAT_DEPTH    2'h2

// timing: clock rate and documented times
`define CLK_HZ           250000000
`define QUALIFY_MS       2000
`define GENLOCK_MS       15000
// the two times above counted at the clock rate, written sized: the 15 s
// product overflows a signed int if left as an expression
`define QUALIFY_CYC      32'h1DCD_6500
`define GENLOCK_CYC      32'hDF84_7580
`define BRIEF_CYC        32'h0000_0010

`endif

// ### refsel_pkg.sv
// types shared by the reference lock controller
package refsel_pkg;

  typedef enum logic [2:0] {
    SRC_INTERNAL      = 3'h0,
    SRC_GENLOCK       = 3'h1,
    SRC_GENLOCK_TC    = 3'h2,
    SRC_FREQ_REF      = 3'h3,
    SRC_SAT_FREQ_PH   = 3'h4,
    SRC_SAT_FREQ_ONLY = 3'h5
  } lock_src_e;

  typedef enum logic [2:0] {
    LK_INTERNAL  = 3'h0,
    LK_LOST      = 3'h1,
    LK_LOCKING   = 3'h2,
    LK_LOCKED    = 3'h3,
    LK_FREQ_REF  = 3'h4
  } lock_stat_e;

  typedef enum logic [1:0] {
    FMT_NONE = 2'h0,
    FMT_525  = 2'h1,
    FMT_625  = 2'h2
  } ref_fmt_e;

  typedef enum logic [2:0] {
    SAT_OFF       = 3'h0,
    SAT_ACQUIRING = 3'h1,
    SAT_TIME      = 3'h2,
    SAT_BASIC     = 3'h3,
    SAT_BETTER    = 3'h4,
    SAT_PHASE     = 3'h5,
    SAT_IDLE      = 3'h6
  } sat_stat_e;

  typedef enum logic [2:0] {
    NTP_OPT_OFF   = 3'h0,
    NTP_DISABLED  = 3'h1,
    NTP_ACQUIRING = 3'h2,
    NTP_LOCKED    = 3'h3,
    NTP_SERVER    = 3'h4
  } ntp_stat_e;

  typedef enum logic [2:0] {
    TC_IGNORING = 3'h0,
    TC_START    = 3'h1,
    TC_SEARCH   = 3'h3,
    TC_FOUND    = 3'h2,
    TC_LOCKING  = 3'h6,
    TC_LOCKED   = 3'h7
  } tc_stat_e;

  // genlock sequencer, gray codes along the acquisition path
  typedef enum logic [2:0] {
    GS_IDLE    = 3'h0,
    GS_QUALIFY = 3'h1,
    GS_COARSE  = 3'h3,
    GS_FINE_SC = 3'h2,
    GS_FINE_SCH= 3'h6,
    GS_LOCKED  = 3'h7,
    GS_LOST    = 3'h5
  } gen_state_e;

  typedef enum logic [1:0] {
    DEPTH_TIME    = 2'h0,
    DEPTH_FREQ    = 2'h1,
    DEPTH_PHASE   = 2'h2
  } sat_depth_e;

  // indications from the reference front ends
  typedef struct packed {
    logic     video_present;
    ref_fmt_e video_fmt;
    logic     coarse_aligned;
    logic     sc_aligned;
    logic     sch_aligned;
    logic     tc_valid;
    logic     tc_aligned;
    logic     freq_present;
    logic     freq_locked;
    logic     sat_enabled;
    logic     sat_fix;
    logic     sat_time_ok;
    logic     sat_basic_ok;
    logic     sat_better_ok;
    logic     sat_phase_ok;
    logic     ntp_enabled;
    logic     ntp_client;
    logic     ntp_server;
    logic     ntp_synced;
  } ref_in_s;

  // steering of the timebase loop
  typedef struct packed {
    lock_src_e active_src;
    logic      lock_freq;
    logic      lock_phase;
    logic      coarse_slew;
    logic      fine_slew;
    logic      discipline;
  } steer_s;

endpackage : refsel_pkg

// ### tb_top.sv
// self-checking testbench for the reference lock controller
`timescale 1ns/1ps
`include "refsel_defs.svh"
module tb_top;
  import refsel_pkg::*;
  // short counts keep the run brief
  localparam logic [31:0] QCYC = 32'h0000_0014;
  localparam logic [31:0] GCYC = 32'h0000_00C8;
  logic        clk_sys  = 1'b0;
  logic        rst      = 1'b1;
  logic [7:0]  addr     = 8'h00;
  logic [31:0] wdata    = 32'h0000_0000;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic        video_on = 1'b0;
  logic        freq_on  = 1'b0;
  logic        sat_on   = 1'b0;
  logic        tc_on    = 1'b0;
  logic [3:0]  ntp_cfg  = 4'h0;
  ref_fmt_e    fmt      = FMT_NONE;
  logic [31:0] rdata;
  ref_in_s     ref_in;
  steer_s      steer;
  logic        lost_event;
  logic [31:0] d;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cyc        = 0;

  reference_lock_controller #(.QUALIFY_CYCLES(QCYC), .GENLOCK_CYCLES(GCYC)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ref_in(ref_in), .steer(steer), .lost_event(lost_event));
  ref_source ref_u (
    .clk_sys(clk_sys), .video_on(video_on), .fmt(fmt), .freq_on(freq_on),
    .sat_on(sat_on), .tc_on(tc_on), .ntp_cfg(ntp_cfg), .steer(steer), .ref_in(ref_in));

  always #2 clk_sys = ~clk_sys;
  // ****************
  // bus and checks
  // ****************
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask : wr_reg
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd   <= 1'b0;
    @(posedge clk_sys);
    v = rdata;
  endtask : rd_reg
  task automatic wait_field(input int lsb, input logic [2:0] exp);
    for (int i = 0; i < 400; i++)
    begin
      rd_reg(`OFS_STATUS, d);
      if (d[lsb +: 3] === exp)
        break;
    end
    chk("status field", {29'h0, d[lsb +: 3]}, {29'h0, exp});
  endtask : wait_field
  task automatic clear_event();
    wr_reg(`OFS_EVENT, 32'h0000_0001);
    rd_reg(`OFS_EVENT, d);
    chk("event clear", d, 32'h0000_0000);
  endtask : clear_event
  // ****************
  // scenarios
  // ****************
  task automatic t_defaults();
    rd_reg(`OFS_LOCK_MODE, d);
    chk("lock mode", d, 32'h0000_0000);
    rd_reg(`OFS_UNLOCK_MODE, d);
    chk("unlock mode", d, 32'h0000_0001);
    rd_reg(`OFS_SAT_DEPTH, d);
    chk("sat depth", d, 32'h0000_0002);
    rd_reg(8'h20, d);
    chk("unmapped", d, 32'h0000_0000);
    wait_field(`FLD_LOCK_LSB, 3'h0);
    wait_field(`FLD_TC_LSB, 3'h0);
    wait_field(`FLD_SAT_LSB, 3'h0);
  endtask : t_defaults
  task automatic t_access();
    wr_reg(`OFS_LOCK_MODE, 32'h0000_0006);
    rd_reg(`OFS_LOCK_MODE, d);
    chk("mode above range", d, 32'h0000_0000);
    wr_reg(`OFS_LOCK_MODE, 32'h0000_0004);
    rd_reg(`OFS_LOCK_MODE, d);
    chk("sat mode option off", d, 32'h0000_0000);
    wr_reg(`OFS_STATUS, 32'hFFFF_FFFF);
    wait_field(`FLD_SRC_LSB, 3'h0);
    wr_reg(`OFS_LOCK_MODE, 32'h0000_0001);
    wait_field(`FLD_LOCK_LSB, 3'h0);
    wr_reg(`OFS_LOCK_MODE, 32'h0000_0000);
  endtask : t_access
  // genlock with a frequency reference present too, then an unknown format
  task automatic t_genlock();
    wr_reg(`OFS_LOCK_MODE, 32'h0000_0001);
    fmt      <= FMT_625;
    video_on <= 1'b1;
    freq_on  <= 1'b1;
    wait_field(`FLD_LOCK_LSB, 3'h2);
    wait_field(`FLD_LOCK_LSB, 3'h3);
    chk("format", {30'h0, d[5:4]}, 32'h0000_0002);
    chk("source", {29'h0, d[22:20]}, 32'h0000_0001);
    chk("freq and phase", {30'h0, steer.lock_freq, steer.lock_phase}, 32'h3);
    chk("slew", {30'h0, steer.coarse_slew, steer.fine_slew}, 32'h1);
    wait_field(`FLD_TC_LSB, 3'h0);
    fmt      <= ref_fmt_e'(2'h3);
    freq_on  <= 1'b0;
    wait_field(`FLD_LOCK_LSB, 3'h1);
    video_on <= 1'b0;
    wr_reg(`OFS_LOCK_MODE, 32'h0000_0000);
    clear_event();
  endtask : t_genlock
  task automatic t_relock(input logic pol);
    wr_reg(`OFS_UNLOCK_MODE, {31'h0, pol});
    wr_reg(`OFS_LOCK_MODE, 32'h0000_0001);
    fmt      <= FMT_525;
    video_on <= 1'b1;
    wait_field(`FLD_LOCK_LSB, 3'h3);
    chk("format", {30'h0, d[5:4]}, 32'h0000_0001);
    video_on <= 1'b0;
    // lost shows for one cycle only, then the absent reference reads internal
    wait_field(`FLD_LOCK_LSB, 3'h0);
    rd_reg(`OFS_EVENT, d);
    chk("lost event", d, 32'h0000_0001);
    chk("lost flag", {31'h0, lost_event}, 32'h1);
    clear_event();
    video_on <= 1'b1;
    if (pol)
      wait_field(`FLD_LOCK_LSB, 3'h3);
    else
    begin
      repeat (150) @(posedge clk_sys);
      wait_field(`FLD_SRC_LSB, 3'h0);
    end
    video_on <= 1'b0;
    wr_reg(`OFS_LOCK_MODE, 32'h0000_0000);
    repeat (4) @(posedge clk_sys);
    clear_event();
  endtask : t_relock
  task automatic t_freq();
    wr_reg(`OFS_LOCK_MODE, 32'h0000_0003);
    freq_on <= 1'b1;
    wait_field(`FLD_LOCK_LSB, 3'h4);
    chk("source", {29'h0, d[22:20]}, 32'h0000_0003);
    chk("freq only", {30'h0, steer.lock_freq, steer.lock_phase}, 32'h2);
    freq_on <= 1'b0;
    wr_reg(`OFS_LOCK_MODE, 32'h0000_0000);
  endtask : t_freq
  task automatic t_sat(input logic [2:0] md, input logic [1:0] depth, input logic [2:0] exp);
    sat_on <= 1'b1;
    wr_reg(`OFS_SAT_DEPTH, {30'h0, depth});
    wr_reg(`OFS_LOCK_MODE, {29'h0, md});
    wait_field(`FLD_SAT_LSB, exp);
    chk("discipline", {31'h0, steer.discipline}, 32'h1);
    wr_reg(`OFS_LOCK_MODE, 32'h0000_0000);
    sat_on <= 1'b0;
  endtask : t_sat
  task automatic t_timecode();
    wr_reg(`OFS_LOCK_MODE, 32'h0000_0002);
    tc_on    <= 1'b1;
    video_on <= 1'b1;
    wait_field(`FLD_TC_LSB, 3'h7);
    video_on <= 1'b0;
    tc_on    <= 1'b0;
    wr_reg(`OFS_LOCK_MODE, 32'h0000_0000);
    repeat (4) @(posedge clk_sys);
    clear_event();
  endtask : t_timecode
  task automatic t_ntp();
    ntp_cfg <= 4'h8;
    wait_field(`FLD_NTP_LSB, 3'h1);
    ntp_cfg <= 4'hC;
    wait_field(`FLD_NTP_LSB, 3'h2);
    ntp_cfg <= 4'hD;
    wait_field(`FLD_NTP_LSB, 3'h3);
    ntp_cfg <= 4'hA;
    wait_field(`FLD_NTP_LSB, 3'h4);
    ntp_cfg <= 4'h0;
    wait_field(`FLD_NTP_LSB, 3'h0);
  endtask : t_ntp

  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_defaults();
    t_access();
    t_genlock();
    t_relock(1'b1);
    t_relock(1'b0);
    t_freq();
    t_sat(3'h4, 2'h0, 3'h2);
    t_sat(3'h4, 2'h2, 3'h5);
    t_sat(3'h5, 2'h1, 3'h4);
    t_timecode();
    t_ntp();
    report_and_stop();
  end
endmodule : tb_top

bind reference_lock_controller ref_lock_chk #(
  .QUALIFY_CYCLES(QUALIFY_CYCLES), .GENLOCK_CYCLES(GENLOCK_CYCLES)) chk_u (
  .clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .ref_in(ref_in), .steer(steer), .lost_event(lost_event));
